// >>> design/cas_host.sv
// Host controller that drives the core memory address sequencer pins
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps

// Overview of operation
// - Each count/transpose carries one direction level
// - Interlace select held static on own line
// - Mode level plus sync picks mode
// - Separate line per control and strobe
// - Own lines for count, forward, reverse, transpose
// - Direction settled 3.5 us before pulse
// - Pulses only after previous cycle ends
module cas_host (
   // Clock, reset, enable
   input  wire  logic                  clock,
   input  wire  logic                  rst_n,
   input  wire  logic                  ce,
   // Software register port
   input  wire  logic [7:0]            reg_addr,
   input  wire  logic [31:0]           reg_wdata,
   input  wire  logic                  reg_we,
   input  wire  logic                  reg_re,
   output logic       [31:0]           reg_rdata,
   // Memory pins
   output cas_pkg::cas_pins_out_t      pins_o,
   input  wire  cas_pkg::cas_pins_in_t pins_i
);
   import cas_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      cas_st_t           st;
      cas_cmd_t          cmd;
      logic [11:0]       cnt;
      logic [11:0]       lim;
      logic [2:0]        ctrl;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
      logic [ADDR_W-1:0] addr_back;
      logic [WORD_W-1:0] word_back;
      logic              refused;
      logic              op_t;
      logic              op_n;
      logic [31:0]       rdata;
      cas_pins_out_t     pins;
   } cas_state_t;

   cas_state_t q, d;
   logic       cmd_wr;
   logic       any_pulse;

   assign cmd_wr    = reg_we && (reg_addr == OFS_CMD);
   assign reg_rdata = q.rdata;
   assign pins_o    = q.pins;
   // Any control pulse, shared by the setup and width checks
   assign any_pulse = q.pins.addr_strobe | q.pins.count | q.pins.transpose | q.pins.load_sync
                    | q.pins.unload_sync | q.pins.master_clr | q.pins.addr_clr | q.pins.word_clr
                    | q.pins.word_strobe;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      d = q;
      d.rdata = '0;
      d.op_t = pins_i.op_state;
      d.op_n = pins_i.op_state_n;
      // Register writes
      if (reg_we) begin
         unique case (reg_addr)
            OFS_CTRL:   d.ctrl = reg_wdata[2:0];
            OFS_ADDR:   d.addr = reg_wdata[ADDR_W-1:0];
            OFS_WDATA:  d.wdata = reg_wdata[WORD_W-1:0];
            OFS_STATUS: if (reg_wdata[STS_REFUSED]) d.refused = 1'b0;
            default: ;
         endcase
      end
      // Register reads, data valid next cycle only
      if (reg_re) begin
         unique case (reg_addr)
            OFS_CTRL:    d.rdata = {29'h0, q.ctrl};
            OFS_ADDR:    d.rdata = {22'h0, q.addr};
            OFS_WDATA:   d.rdata = {8'h00, q.wdata};
            OFS_STATUS:  d.rdata = {28'h0, q.refused, q.op_n, q.op_t, (q.st != ST_IDLE)};
            OFS_ADDR_BACK: d.rdata = {22'h0, q.addr_back};
            OFS_WORD_BACK: d.rdata = {8'h00, q.word_back};
            default:     d.rdata = 32'h0000_0000;
         endcase
      end
      // Command sequencer
      unique case (q.st)
         ST_IDLE: begin
            // Interlace select only moves between operations
            d.pins.interlace_auto_step = q.ctrl[CTRL_IL];
            // Codes outside the map are ignored when idle, but refused like any other command write mid cycle
            if (cmd_wr && (reg_wdata[3:0] != 4'h0) && (reg_wdata[3:0] <= 4'h9)) begin
               d.cmd = cas_cmd_t'(reg_wdata[3:0]);
               d.cnt = 12'h000;
               d.st = ST_SETUP;
               d.pins.addr = q.addr;
               d.pins.word = q.wdata;
               // Exactly one direction level goes with every pulse
               d.pins.forward = ~q.ctrl[CTRL_REV];
               d.pins.reverse = q.ctrl[CTRL_REV];
               // Mode level stands through the whole cycle
               d.pins.memory_operation_select = q.ctrl[CTRL_MEM];
            end
         end
         ST_SETUP: begin
            // Direction and level inputs settle before zero time
            if (q.cnt == SETTLE_CYC - 12'h001) begin
               d.cnt = 12'h000;
               d.st = ST_PULSE;
               unique case (q.cmd)
                  CMD_ASTB:   d.pins.addr_strobe = 1'b1;
                  CMD_COUNT:  d.pins.count = 1'b1;
                  CMD_TRANS:  d.pins.transpose = 1'b1;
                  CMD_LOAD:   d.pins.load_sync = 1'b1;
                  CMD_UNLOAD: d.pins.unload_sync = 1'b1;
                  CMD_MCLR:   d.pins.master_clr = 1'b1;
                  CMD_ACLR:   d.pins.addr_clr = 1'b1;
                  CMD_WCLR:   d.pins.word_clr = 1'b1;
                  CMD_WSTB:   d.pins.word_strobe = 1'b1;
                  default: ;
               endcase
            end else begin
               d.cnt = q.cnt + 12'h001;
            end
         end
         ST_PULSE: begin
            if (q.cnt == PULSE_CYC - 12'h001) begin
               d.cnt = 12'h000;
               d.st = ST_WAIT;
               d.pins.addr_strobe = 1'b0;
               d.pins.count = 1'b0;
               d.pins.transpose = 1'b0;
               d.pins.load_sync = 1'b0;
               d.pins.unload_sync = 1'b0;
               d.pins.master_clr = 1'b0;
               d.pins.addr_clr = 1'b0;
               d.pins.word_clr = 1'b0;
               d.pins.word_strobe = 1'b0;
               // Load and unload wait lengths counted from zero time, the rising edge of the pulse; others from its falling edge
               unique case (q.cmd)
                  // With interlace on, the memory steps by itself: no count pulse follows
                  CMD_LOAD, CMD_UNLOAD: d.lim = q.pins.memory_operation_select ? MEM_WAIT : BUF_WAIT;
                  CMD_MCLR: d.lim = CLR_CYC;
                  default:  d.lim = ASET_CYC;
               endcase
            end else begin
               d.cnt = q.cnt + 12'h001;
            end
         end
         ST_WAIT: begin
            // Next pulse only once the previous cycle is over
            if (q.cnt == q.lim - 12'h001) begin
               d.st = ST_IDLE;
               d.cnt = 12'h000;
               // Readback waits out the settle time so the lines have stopped moving
               d.addr_back = pins_i.addr;
               if (q.cmd == CMD_UNLOAD) begin
                  d.word_back = pins_i.word;
               end
            end else begin
               d.cnt = q.cnt + 12'h001;
            end
         end
      endcase
      // Commands during a cycle are dropped; the set wins over a clear
      if (cmd_wr && (q.st != ST_IDLE)) begin
         d.refused = 1'b1;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   // Forward stands high in reset so the direction pair is never equal
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: ST_IDLE, cmd: CMD_NONE, pins: '{forward: 1'b1, default: '0}, default: '0};
      end else if (ce) begin
         q <= d;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_dir_pair;
      @(posedge clock) disable iff (!rst_n)
      q.pins.forward != q.pins.reverse;
   endproperty
   a_dir_pair: assert property (p_dir_pair) else $error("direction levels not complementary");

   property p_one_pulse;
      @(posedge clock) disable iff (!rst_n)
      $onehot0({q.pins.addr_strobe, q.pins.count, q.pins.transpose, q.pins.load_sync,
                q.pins.unload_sync, q.pins.master_clr, q.pins.addr_clr, q.pins.word_clr,
                q.pins.word_strobe});
   endproperty
   a_one_pulse: assert property (p_one_pulse) else $error("two control pulses at once");

   property p_setup_len;
      @(posedge clock) disable iff (!rst_n)
      $rose(any_pulse) |-> ($past(q.cnt) == SETTLE_CYC - 12'h001) && $past(q.st == ST_SETUP);
   endproperty
   a_setup_len: assert property (p_setup_len) else $error("pulse before direction settled");

   property p_dir_stable;
      @(posedge clock) disable iff (!rst_n)
      (q.st == ST_PULSE) || (q.st == ST_SETUP && $past(q.st == ST_SETUP)) |-> $stable(q.pins.reverse);
   endproperty
   a_dir_stable: assert property (p_dir_stable) else $error("direction moved before zero time");

   property p_pulse_len;
      @(posedge clock) disable iff (!rst_n)
      $fell(any_pulse) |-> $past(q.cnt) == PULSE_CYC - 12'h001;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse width wrong");

   property p_cycle_len;
      @(posedge clock) disable iff (!rst_n)
      (q.st == ST_IDLE) && $past(q.st == ST_WAIT) && ((q.cmd == CMD_LOAD) || (q.cmd == CMD_UNLOAD))
      |-> $past(q.cnt) == ($past(q.pins.memory_operation_select) ? MEM_WAIT : BUF_WAIT) - 12'h001;
   endproperty
   a_cycle_len: assert property (p_cycle_len) else $error("cycle ended at wrong time");

   property p_il_static;
      @(posedge clock) disable iff (!rst_n)
      $changed(q.pins.interlace_auto_step) |-> $past(q.st) == ST_IDLE;
   endproperty
   a_il_static: assert property (p_il_static) else $error("interlace select moved mid cycle");

   property p_mode_hold;
      @(posedge clock) disable iff (!rst_n)
      (q.st == ST_PULSE) || (q.st == ST_WAIT) |-> $stable(q.pins.memory_operation_select);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode level moved during cycle");

   property p_addr_hold;
      @(posedge clock) disable iff (!rst_n)
      (q.st != ST_IDLE) && $past(q.st != ST_IDLE) |-> $stable(q.pins.addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address lines moved mid operation");

   // A write that arrives mid cycle may only raise the flag, never restart the sequencer
   property p_busy_refuse;
      @(posedge clock) disable iff (!rst_n)
      ce && cmd_wr && (q.st != ST_IDLE) |=> q.refused && $stable(q.cmd);
   endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("command taken during a cycle");

   // No pulse may follow a master clear until the recovery time is spent
   property p_clr_gap;
      @(posedge clock) disable iff (!rst_n)
      (q.st == ST_IDLE) && $past(q.st == ST_WAIT) && (q.cmd == CMD_MCLR) |-> $past(q.cnt) == CLR_CYC - 12'h001;
   endproperty
   a_clr_gap: assert property (p_clr_gap) else $error("master clear recovery cut short");

   // Direction is taken from control at command start, not at zero time
   property p_dir_latch;
      @(posedge clock) disable iff (!rst_n)
      (q.st == ST_SETUP) && $past(q.st == ST_IDLE) |-> q.pins.reverse == $past(q.ctrl[CTRL_REV]);
   endproperty
   a_dir_latch: assert property (p_dir_latch) else $error("direction level not taken from control");

   // Mode level is frozen at command start so it cannot move under the sync pulse
   property p_mode_latch;
      @(posedge clock) disable iff (!rst_n)
      (q.st == ST_SETUP) && $past(q.st == ST_IDLE) |-> q.pins.memory_operation_select == $past(q.ctrl[CTRL_MEM]);
   endproperty
   a_mode_latch: assert property (p_mode_latch) else $error("mode level not taken from control");

   // A count pulse only ever follows a count command
   property p_count_own;
      @(posedge clock) disable iff (!rst_n)
      $rose(q.pins.count) |-> q.cmd == CMD_COUNT;
   endproperty
   a_count_own: assert property (p_count_own) else $error("count pulse without count command");

   // A transpose pulse only ever follows a transpose command
   property p_trans_own;
      @(posedge clock) disable iff (!rst_n)
      $rose(q.pins.transpose) |-> q.cmd == CMD_TRANS;
   endproperty
   a_trans_own: assert property (p_trans_own) else $error("transpose pulse without transpose command");

   c_count:  cover property (@(posedge clock) disable iff (!rst_n) $rose(q.pins.count));
   c_trans:  cover property (@(posedge clock) disable iff (!rst_n) $rose(q.pins.transpose));
   c_memld:  cover property (@(posedge clock) disable iff (!rst_n)
                             $rose(q.pins.load_sync) && q.pins.memory_operation_select);
   c_mclr:   cover property (@(posedge clock) disable iff (!rst_n) $rose(q.pins.master_clr));
   c_ilload: cover property (@(posedge clock) disable iff (!rst_n)
                             $rose(q.pins.load_sync) && q.pins.interlace_auto_step);

endmodule : cas_host

// >>> inc/cas_pkg.sv
// Constants, register map and carrier types of the core memory address sequencer host
package cas_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_W = 10;
   localparam int WORD_W = 24;

   // ****************************************
   // Timing, clock 8 ns
   // ****************************************
   localparam int CLK_PERIOD_NS  = 8;
   localparam int DIR_SETTLE_NS  = 3500;
   localparam int PULSE_MIN_NS   = 500;
   localparam int ADDR_SETTLE_NS = 1500;
   localparam int BUF_CYCLE_NS   = 5000;
   localparam int MEM_CYCLE_NS   = 8000;
   localparam int CLR_RECOVER_NS = 25000;
   localparam logic [11:0] SETTLE_CYC = 12'((DIR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] PULSE_CYC  = 12'((PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] ASET_CYC   = 12'((ADDR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] BUF_CYC    = 12'((BUF_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] MEM_CYC    = 12'((MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] CLR_CYC    = 12'((CLR_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] BUF_WAIT   = BUF_CYC - PULSE_CYC;
   localparam logic [11:0] MEM_WAIT   = MEM_CYC - PULSE_CYC;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] OFS_CTRL      = 8'h00;
   localparam logic [7:0] OFS_ADDR      = 8'h04;
   localparam logic [7:0] OFS_WDATA     = 8'h08;
   localparam logic [7:0] OFS_CMD       = 8'h0C;
   localparam logic [7:0] OFS_STATUS    = 8'h10;
   localparam logic [7:0] OFS_ADDR_BACK = 8'h14;
   localparam logic [7:0] OFS_WORD_BACK = 8'h18;
   localparam int CTRL_REV = 0;
   localparam int CTRL_MEM = 1;
   localparam int CTRL_IL  = 2;
   localparam int STS_REFUSED = 3;

   typedef enum logic [3:0] {
      CMD_NONE = 4'h0, CMD_ASTB = 4'h1, CMD_COUNT = 4'h2, CMD_TRANS = 4'h3,
      CMD_LOAD = 4'h4, CMD_UNLOAD = 4'h5, CMD_MCLR = 4'h6, CMD_ACLR = 4'h7,
      CMD_WCLR = 4'h8, CMD_WSTB = 4'h9
   } cas_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1, ST_SETUP = 4'h2, ST_PULSE = 4'h4, ST_WAIT = 4'h8
   } cas_st_t;

   // ****************************************
   // Pin carriers
   // ****************************************
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              addr_strobe;
      logic              count;
      logic              transpose;
      logic              forward;
      logic              reverse;
      logic              load_sync;
      logic              unload_sync;
      logic              master_clr;
      logic              addr_clr;
      logic              word_clr;
      logic              memory_operation_select;
      logic              interlace_auto_step;
      logic [WORD_W-1:0] word;
      logic              word_strobe;
   } cas_pins_out_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] word;
      logic              op_state;
      logic              op_state_n;
   } cas_pins_in_t;

endpackage : cas_pkg

// >>> sim/cas_mem_model.sv
// Behavioural model of the core memory address sequencer seen by the host
`timescale 1ns/1ps
module cas_mem_model (
   // Lines from the host
   input  wire cas_pkg::cas_pins_out_t host_pins,
   // Lines back to the host
   output cas_pkg::cas_pins_in_t       mem_pins,
   output int                          faults
);
   import cas_pkg::*;
   // ****************************************
   // Registers and timing bookkeeping
   // ****************************************
   logic [ADDR_W-1:0] hold_q = '0, tr_q = '0, a_o = '0;
   logic [WORD_W-1:0] wr_q = '0;
   logic [WORD_W-1:0] mem [2**ADDR_W];
   logic              busy_q = 1'b0;
   logic [63:0]       x_sel = '0, y_sel = '0;
   logic              set_cur = 1'b0;
   realtime           t_dir = 0.0, t_end = 0.0;
   initial faults = 0;
   function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a);
      return host_pins.forward ? a + 1'b1 : a - 1'b1;
   endfunction : step
   // Early pulses or a late direction change would upset a real count network
   task automatic pulse_chk(input bit dir);
      if (($realtime < t_end - PULSE_MIN_NS) || (dir && $realtime - t_dir < DIR_SETTLE_NS)) faults++;
   endtask : pulse_chk
   always @(host_pins.forward) t_dir = $realtime;
   always @(posedge host_pins.count) begin
      pulse_chk(1'b1);
      hold_q = step(hold_q);
   end
   always @(posedge host_pins.transpose) begin
      pulse_chk(1'b1);
      tr_q = step(hold_q);
      hold_q = tr_q;
   end
   always @(posedge host_pins.addr_strobe) begin
      pulse_chk(1'b0);
      hold_q = host_pins.addr;
   end
   always @(posedge host_pins.addr_clr or posedge host_pins.master_clr) hold_q = '0;
   always @(posedge host_pins.word_clr or posedge host_pins.master_clr) wr_q = '0;
   always @(posedge host_pins.word_strobe) wr_q = host_pins.word;
   always @(posedge host_pins.load_sync or posedge host_pins.unload_sync) begin
      if ($realtime < t_end - PULSE_MIN_NS) faults++;
      t_end = $realtime + (host_pins.memory_operation_select ? MEM_CYCLE_NS : BUF_CYCLE_NS);
      busy_q = 1'b1;
      // One X and one Y winding per access; load steers set current, unload reset
      x_sel = 64'h1 << hold_q[ADDR_W/2-1:0];
      y_sel = 64'h1 << hold_q[ADDR_W-1:ADDR_W/2];
      set_cur = host_pins.load_sync;
      if (!$onehot(x_sel) || !$onehot(y_sel) || (set_cur == host_pins.unload_sync)) faults++;
      if (host_pins.load_sync) mem[hold_q] = wr_q;
      else wr_q <= #1000 mem[hold_q];
      if (host_pins.interlace_auto_step) hold_q = step(hold_q);
      #(t_end - $realtime) busy_q = 1'b0;
   end
   // Address outputs show garbage until settled, so early sampling is caught
   always @(hold_q) begin
      a_o <= ~hold_q;
      a_o <= #1000 hold_q;
   end
   assign mem_pins = '{addr: a_o, word: wr_q, op_state: busy_q, op_state_n: ~busy_q};
endmodule : cas_mem_model

// >>> sim/tb.sv
// Self-checking bench for the core memory address sequencer host
`timescale 1ns/1ps
module tb;
   import cas_pkg::*;
   logic          clock = 1'b0;
   logic          rst_n = 1'b0;
   logic [7:0]    reg_addr = 8'h00;
   logic [31:0]   reg_wdata = 32'h0, reg_rdata, rv;
   logic          reg_we = 1'b0, reg_re = 1'b0, ce = 1'b1;
   cas_pins_out_t pins_o;
   cas_pins_in_t  pins_i;
   int            faults, num_errors = 0, total_checks = 0;
   always #4 clock = ~clock;
   cas_host dut_u (.clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .pins_o(pins_o), .pins_i(pins_i));
   cas_mem_model mem_u (.host_pins(pins_o), .mem_pins(pins_i), .faults(faults));
   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic close_out;
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_we <= 1'b1;
      @(posedge clock);
      reg_we <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge clock);
      reg_re <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rv, e);
   endtask : rchk
   // Bounded poll so a stuck busy flag cannot hang the run
   task automatic idle_wait;
      int n;
      n = 0;
      do begin
         rd(OFS_STATUS);
         n++;
      end while (rv[0] !== 1'b0 && n < 3000);
      chk(32'(n < 3000), 32'h1);
   endtask : idle_wait
   task automatic cmd(input logic [3:0] c);
      wr(OFS_CMD, {28'h0, c});
      idle_wait();
   endtask : cmd
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      chk(pins_o.forward, 32'h1);
      rchk(OFS_STATUS, 32'h4);
      rchk(8'h1C, 32'h0);
      ce <= 1'b0;
      wr(OFS_CTRL, 32'h7);
      ce <= 1'b1;
      rchk(OFS_CTRL, 32'h0);
      wr(OFS_CTRL, 32'h7);
      rchk(OFS_CTRL, 32'h7);
      wr(OFS_CTRL, 32'h0);
   endtask : t_reset
   task automatic t_step;
      wr(OFS_ADDR, 32'h3FF);
      cmd(CMD_ASTB);
      rchk(OFS_ADDR_BACK, 32'h3FF);
      cmd(CMD_COUNT);
      rchk(OFS_ADDR_BACK, 32'h0);
      wr(OFS_CTRL, 32'h1);
      cmd(CMD_COUNT);
      rchk(OFS_ADDR_BACK, 32'h3FF);
      cmd(CMD_TRANS);
      rchk(OFS_ADDR_BACK, 32'h3FE);
      wr(OFS_CTRL, 32'h0);
      cmd(CMD_TRANS);
      rchk(OFS_ADDR_BACK, 32'h3FF);
      cmd(CMD_ACLR);
      rchk(OFS_ADDR_BACK, 32'h0);
   endtask : t_step
   task automatic t_refuse;
      wr(OFS_CMD, {28'h0, CMD_COUNT});
      wr(OFS_CMD, {28'h0, CMD_COUNT});
      idle_wait();
      rchk(OFS_ADDR_BACK, 32'h1);
      rchk(OFS_STATUS, 32'hC);
      wr(OFS_STATUS, 32'h8);
      rchk(OFS_STATUS, 32'h4);
   endtask : t_refuse
   task automatic t_data;
      wr(OFS_ADDR, 32'h2A);
      cmd(CMD_ASTB);
      wr(OFS_WDATA, 32'hA5C3E1);
      cmd(CMD_WSTB);
      wr(OFS_CTRL, 32'h2);
      wr(OFS_CMD, {28'h0, CMD_LOAD});
      repeat (450) @(posedge clock);
      rchk(OFS_STATUS, 32'h3);
      idle_wait();
      cmd(CMD_WCLR);
      cmd(CMD_UNLOAD);
      rchk(OFS_WORD_BACK, 32'hA5C3E1);
      wr(OFS_CTRL, 32'h0);
      cmd(CMD_UNLOAD);
      rchk(OFS_WORD_BACK, 32'hA5C3E1);
      rchk(OFS_ADDR_BACK, 32'h2A);
   endtask : t_data
   task automatic t_interlace;
      wr(OFS_CTRL, 32'h4);
      cmd(CMD_LOAD);
      cmd(CMD_LOAD);
      rchk(OFS_ADDR_BACK, 32'h2C);
      wr(OFS_CTRL, 32'h5);
      cmd(CMD_LOAD);
      rchk(OFS_ADDR_BACK, 32'h2B);
      wr(OFS_CTRL, 32'h0);
      cmd(CMD_MCLR);
      rchk(OFS_ADDR_BACK, 32'h0);
      chk(32'(faults), 32'h0);
   endtask : t_interlace
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_reset();
      t_step();
      t_refuse();
      t_data();
      t_interlace();
      close_out();
   end
   initial begin
      repeat (60000) @(posedge clock);
      num_errors++;
      close_out();
   end
endmodule : tb
